// ### shared/ea_pkg.sv
// constants and types shared by the exception arbiter
// What this block does
// - entry pushes core registers, then sets the global interrupt mask
// - return pops the saved core registers so the program resumes
// - requests are latched; arbitration yields a vector code for the core
// - a latched interrupt is not pre-empted by another request; only a reset source overrides it
// - hardware interrupts wait for the current instruction to finish
// - at a boundary, take a flag request only if unmasked and source-enabled
// - among pending requests the highest fixed priority goes first
// - a request pending at return is taken before the prefetched opcode runs
// - entry never pushes the high index register
// - the software interrupt instruction ignores the global mask
// - software interrupt stacks pc; hardware interrupt stacks pc minus one
// - fixed order: reset, software, then flags 1 to 16
// - low flag register: bits 7..2 show flags 6..1, bits 1..0 read zero
// - mid flag register: bits 7..0 show flags 14..7
// - high flag register: bits 1..0 show flags 16..15, rest read zero
// - all reset sources share top priority and override any interrupt
// - a break request forces the software interrupt vector
// - in break, peripheral flags are protected unless clear enable is set
// - a flag cleared in break with clearing enabled stays cleared
// - two-step clears stay protected in break; second step works afterwards
// - break clear enable is read/write: 1 clearable, 0 protected
package ea_pkg;

  // ****************************************
  // register map (index, byte address = 4 * index)
  // ****************************************
  localparam logic [15:0] EA_IDX_BRK_CTRL = 16'hFE03;
  localparam logic [15:0] EA_IDX_PEND_LOW = 16'hFE04;
  localparam logic [15:0] EA_IDX_PEND_MID = 16'hFE05;
  localparam logic [15:0] EA_IDX_PEND_HIGH = 16'hFE06;
  localparam int EA_ADDR_W = 18;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int EA_BREAK_CLEAR_ENABLE_BIT = 0;
  localparam logic EA_BREAK_CLEAR_ENABLE_RST = 1'b0;
  localparam logic [7:0] EA_PEND_RST = 8'h00;
  localparam int EA_NUM_SRC = 16;

  // ****************************************
  // vector codes and stacking
  // ****************************************
  localparam logic [4:0] EA_VEC_RESET = 5'h00;
  localparam logic [4:0] EA_VEC_SWI = 5'h01;
  localparam logic [4:0] EA_VEC_FLAG_BASE = 5'h02;
  localparam logic [2:0] EA_STACK_ITEMS = 3'h5;

  typedef enum logic [2:0] {
    EA_ST_RUN = 3'b000,
    EA_ST_STACK = 3'b001,
    EA_ST_MASK = 3'b010,
    EA_ST_FETCH = 3'b011,
    EA_ST_UNSTACK = 3'b100
  } ea_state_t;

endpackage : ea_pkg

// ### logic/ea_prio_enc.sv
// fixed priority encoder, index 0 wins
`timescale 1ns/100ps
`default_nettype none
module ea_prio_enc #(
  parameter int N = 16,
  parameter int W = 4
) (
  input wire logic [N-1:0] req,
  output logic any,
  output logic [W-1:0] idx
);

  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = W'(i);
      end
    end
  end

endmodule : ea_prio_enc
`default_nettype wire

// ### logic/ea_arbiter.sv
// exception arbiter: interrupt latch, priority, stacking control, break
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ea_arbiter
  import ea_pkg::*;
#(
  parameter int NSRC = EA_NUM_SRC
) (
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [EA_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral requests and their enables
  input wire logic [NSRC-1:0] irq_req,
  input wire logic [NSRC-1:0] irq_en,
  // core side
  input wire logic core_imask,
  input wire logic instr_done,
  input wire logic swi_exec,
  input wire logic rti_exec,
  input wire logic rst_src,
  output logic stack_push,
  output logic stack_pop,
  output logic [2:0] stack_item,
  output logic stack_pc_minus1,
  output logic set_imask,
  output logic vector_fetch,
  output logic [4:0] vector_sel,
  output logic drop_prefetch,
  // break module and peripherals
  input wire logic brk_req,
  output logic brk_active,
  output logic flag_protect
);

  // ****************************************
  // declarations
  // ****************************************
  ea_state_t state_q, state_d;
  logic [NSRC-1:0] pend_q;
  logic [NSRC-1:0] take_req;
  logic hw_any;
  logic [3:0] hw_idx;
  logic [4:0] vec_q;
  logic pcm1_q;
  logic [2:0] cnt_q;
  logic break_clear_enable_q;
  logic brk_q;
  logic brk_svc_q;
  logic [31:0] prdata_q;
  logic boundary;
  logic rti_end;
  logic take_hw;
  logic take_brk;
  logic take_swi;
  logic take_any;
  logic [4:0] arb_vec;
  logic arb_pcm1;
  logic apb_setup;
  logic apb_wr;
  logic [15:0] reg_idx;
  logic addr_ok;
  logic addr_hit;
  logic [7:0] rd_byte;

  // ****************************************
  // request latch
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= '0;
    end else begin
      pend_q <= irq_req;
    end
  end

  // ****************************************
  // request qualification
  // ****************************************
  // only unmasked, enabled sources compete
  assign take_req = (core_imask ? '0 : (pend_q & irq_en));

  ea_prio_enc #(
    .N(NSRC),
    .W(4)
  ) u_prio (
    .req(take_req),
    .any(hw_any),
    .idx(hw_idx)
  );

  // ****************************************
  // arbitration
  // ****************************************
  // checks happen only when an instruction has fully finished
  assign boundary = (state_q == EA_ST_RUN) && instr_done;
  // end of return: pending work is checked before the prefetched opcode
  assign rti_end = (state_q == EA_ST_UNSTACK) &&
                   (cnt_q == EA_STACK_ITEMS - 3'h1);
  assign take_brk = brk_req;
  assign take_swi = swi_exec;
  assign take_hw = hw_any;
  assign take_any = take_brk || take_swi || take_hw;

  always_comb begin
    arb_vec = EA_VEC_SWI;
    arb_pcm1 = 1'b0;
    // break and software interrupt beat every flag source
    if (take_brk || take_swi) begin
      arb_vec = EA_VEC_SWI;
      arb_pcm1 = 1'b0;
    end else if (take_hw) begin
      arb_vec = EA_VEC_FLAG_BASE + {1'b0, hw_idx};
      arb_pcm1 = 1'b1;
    end
  end

  // ****************************************
  // sequence state machine
  // ****************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      EA_ST_RUN: begin
        if (boundary && take_any) begin
          state_d = EA_ST_STACK;
        end else if (rti_exec) begin
          state_d = EA_ST_UNSTACK;
        end
      end
      EA_ST_STACK: begin
        if (cnt_q == EA_STACK_ITEMS - 3'h1) begin
          state_d = EA_ST_MASK;
        end
      end
      EA_ST_MASK: begin
        state_d = EA_ST_FETCH;
      end
      EA_ST_FETCH: begin
        state_d = EA_ST_RUN;
      end
      EA_ST_UNSTACK: begin
        if (rti_end) begin
          if (take_any) begin
            state_d = EA_ST_STACK;
          end else begin
            state_d = EA_ST_RUN;
          end
        end
      end
      default: begin
        state_d = EA_ST_RUN;
      end
    endcase
    // every reset source overrides whatever is in flight
    if (rst_src) begin
      state_d = EA_ST_FETCH;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= EA_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // stack item counter
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 3'h0;
    end else if (rst_src) begin
      cnt_q <= 3'h0;
    end else if (state_q != state_d) begin
      cnt_q <= 3'h0;
    end else if (state_q == EA_ST_STACK || state_q == EA_ST_UNSTACK) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // ****************************************
  // latched vector
  // ****************************************
  // once latched, only a reset source replaces the code before the fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_q <= EA_VEC_RESET;
    end else if (rst_src) begin
      vec_q <= EA_VEC_RESET;
    end else if ((boundary || rti_end) && take_any) begin
      vec_q <= arb_vec;
    end
  end

  // ****************************************
  // stacked program counter choice
  // ****************************************
  // latched with the vector so a late swi cannot flip it mid push
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcm1_q <= 1'b0;
    end else if (rst_src) begin
      pcm1_q <= 1'b0;
    end else if ((boundary || rti_end) && take_any) begin
      pcm1_q <= arb_pcm1;
    end
  end

  // ****************************************
  // break state
  // ****************************************
  // break is entered when its request wins a boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_svc_q <= 1'b0;
    end else if (rst_src) begin
      brk_svc_q <= 1'b0;
    end else if ((boundary || rti_end) && take_any) begin
      brk_svc_q <= take_brk;
    end
  end

  // break ends at the end of the next return sequence, whichever routine it belongs to
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_q <= 1'b0;
    end else if (rst_src) begin
      brk_q <= 1'b0;
    end else if (state_q == EA_ST_FETCH && brk_svc_q) begin
      brk_q <= 1'b1;
    end else if (rti_end && brk_q) begin
      brk_q <= 1'b0;
    end
  end

  // ****************************************
  // apb decode
  // ****************************************
  // word index decode; sub-word addresses are refused
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign reg_idx = paddr[EA_ADDR_W-1:2];
  assign addr_ok = (paddr[1:0] == 2'b00);

  // ****************************************
  // break clear enable
  // ****************************************

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_clear_enable_q <= EA_BREAK_CLEAR_ENABLE_RST;
    end else if (apb_wr && addr_ok && reg_idx == EA_IDX_BRK_CTRL) begin
      break_clear_enable_q <= pwdata[EA_BREAK_CLEAR_ENABLE_BIT];
    end
  end

  // ****************************************
  // flag protection
  // ****************************************
  // peripherals hold their flags (and any half-done two-step clear)
  // while this is high; a clear done with it low is final
  assign flag_protect = brk_q && !break_clear_enable_q;
  assign brk_active = brk_q;

  // ****************************************
  // apb read side
  // ****************************************
  always_comb begin
    rd_byte = 8'h00;
    addr_hit = addr_ok;
    case (reg_idx)
      EA_IDX_BRK_CTRL: begin
        rd_byte = {7'h00, break_clear_enable_q};
      end
      EA_IDX_PEND_LOW: begin
        rd_byte = {pend_q[5:0], 2'b00};
      end
      EA_IDX_PEND_MID: begin
        rd_byte = pend_q[13:6];
      end
      EA_IDX_PEND_HIGH: begin
        rd_byte = {6'h00, pend_q[15:14]};
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
    if (!addr_ok) begin
      rd_byte = 8'h00;
    end
  end

  // ****************************************
  // apb read data
  // ****************************************
  // data captured in setup so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= {24'h000000, EA_PEND_RST};
    end else if (apb_setup && !pwrite) begin
      prdata_q <= {24'h000000, rd_byte};
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;

  // ****************************************
  // core outputs
  // ****************************************
  // items: 0 pc low, 1 pc high, 2 index low, 3 accumulator, 4 ccr
  // the high index register is never among them
  always_comb begin
    stack_item = 3'h0;
    if (state_q == EA_ST_STACK) begin
      stack_item = cnt_q;
    end else if (state_q == EA_ST_UNSTACK) begin
      stack_item = EA_STACK_ITEMS - 3'h1 - cnt_q;
    end
  end

  assign stack_push = (state_q == EA_ST_STACK);
  assign stack_pop = (state_q == EA_ST_UNSTACK);
  assign stack_pc_minus1 = stack_push && pcm1_q;
  assign set_imask = (state_q == EA_ST_MASK);
  assign vector_fetch = (state_q == EA_ST_FETCH);
  assign vector_sel = vec_q;
  assign drop_prefetch = rti_end && take_any;

endmodule : ea_arbiter
`default_nettype wire

// ### testbench/ea_arbiter_assertions.sv
// port checker for the exception arbiter
`timescale 1ns/100ps
`default_nettype none
module ea_arbiter_assertions
  import ea_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic instr_done,
  input wire logic swi_exec,
  input wire logic rti_exec,
  input wire logic rst_src,
  input wire logic core_imask,
  input wire logic brk_req,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic [2:0] stack_item,
  input wire logic stack_pc_minus1,
  input wire logic set_imask,
  input wire logic vector_fetch,
  input wire logic [4:0] vector_sel
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic idle;
  assign idle = !(stack_push || stack_pop || set_imask || vector_fetch || rti_exec || rst_src);
  property p_push5;
    $rose(stack_push) |-> stack_push [*5] ##1 (set_imask && !stack_push);
  endproperty
  a_push5: assert property (p_push5) else $error("push length");
  property p_fetch;
    set_imask |=> vector_fetch;
  endproperty
  a_fetch: assert property (p_fetch) else $error("no fetch");
  property p_pop5;
    $rose(stack_pop) |-> stack_pop [*5] ##1 !stack_pop;
  endproperty
  a_pop5: assert property (p_pop5) else $error("pop length");
  property p_swi;
    instr_done && idle && swi_exec |=> stack_push && !stack_pc_minus1 ##6 vector_fetch && vector_sel == EA_VEC_SWI;
  endproperty
  a_swi: assert property (p_swi) else $error("swi entry");
  property p_brk;
    instr_done && idle && brk_req && !swi_exec |=> stack_push ##6 vector_fetch && vector_sel == EA_VEC_SWI;
  endproperty
  a_brk: assert property (p_brk) else $error("break entry");
  property p_mask;
    instr_done && idle && core_imask && !swi_exec && !brk_req |=> !stack_push;
  endproperty
  a_mask: assert property (p_mask) else $error("masked entry");
  property p_wait;
    $rose(stack_push) |-> $past(instr_done) || $past(stack_pop);
  endproperty
  a_wait: assert property (p_wait) else $error("entry mid instr");
  property p_rst;
    rst_src |=> vector_fetch && vector_sel == EA_VEC_RESET;
  endproperty
  a_rst: assert property (p_rst) else $error("reset vector");
  property p_items;
    $rose(stack_push) |-> stack_item == 3'h0 ##1 stack_item == 3'h1 ##1 stack_item == 3'h2
      ##1 stack_item == 3'h3 ##1 stack_item == 3'h4;
  endproperty
  a_items: assert property (p_items) else $error("push order");
  property p_unstack;
    $rose(stack_pop) |-> stack_item == 3'h4 ##1 stack_item == 3'h3 ##1 stack_item == 3'h2
      ##1 stack_item == 3'h1 ##1 stack_item == 3'h0;
  endproperty
  a_unstack: assert property (p_unstack) else $error("pop order");
  c_swi: cover property (instr_done && idle && swi_exec);
  c_pop: cover property ($rose(stack_pop));
  c_brk: cover property (instr_done && idle && brk_req);
endmodule : ea_arbiter_assertions
bind ea_arbiter ea_arbiter_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .instr_done(instr_done), .swi_exec(swi_exec), .rti_exec(rti_exec), .rst_src(rst_src),
  .core_imask(core_imask), .brk_req(brk_req), .stack_push(stack_push), .stack_pop(stack_pop),
  .stack_item(stack_item), .stack_pc_minus1(stack_pc_minus1), .set_imask(set_imask), .vector_fetch(vector_fetch),
  .vector_sel(vector_sel));
`default_nettype wire

// ### testbench/ea_core_model.sv
// core stand-in: instruction slots, return requests, mask bit
`timescale 1ns/100ps
`default_nettype none
module ea_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic [2:0] stack_item,
  input wire logic set_imask,
  input wire logic vector_fetch,
  input wire logic hold_mask,
  input wire logic do_rti,
  output logic instr_done,
  output logic rti_exec,
  output logic core_imask
);
  // ****************
  // slots and mask
  // ****************
  logic [1:0] slot_q;
  logic imask_q;
  logic busy;
  assign busy = stack_push | stack_pop | set_imask | vector_fetch;
  assign instr_done = slot_q == 2'h3 && !busy && !do_rti;
  assign rti_exec = slot_q == 2'h3 && !busy && do_rti;
  assign core_imask = imask_q | hold_mask;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_q <= 2'h0;
    end else if (!busy) begin
      slot_q <= slot_q + 2'h1;
    end
  end
  // saved flags come back first on return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_q <= 1'h0;
    end else if (set_imask) begin
      imask_q <= 1'h1;
    end else if (stack_pop && stack_item == 3'h4) begin
      imask_q <= 1'h0;
    end
  end
endmodule : ea_core_model
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the exception arbiter
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ea_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic swi_exec = 1'h0, rst_src = 1'h0, brk_req = 1'h0, hold_mask = 1'h0, do_rti = 1'h0;
  logic [EA_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic [15:0] irq_req = '0, irq_en = '0;
  logic pready, pslverr, instr_done, rti_exec, core_imask, stack_push, stack_pop, pc_m1;
  logic set_imask, vector_fetch, drop_prefetch, brk_active, flag_protect, er, pcm, dp;
  logic [2:0] stack_item;
  logic [4:0] vector_sel;
  int err_count = 0, total_checks = 0, cyc = 0, n;
  always #5 pclk = ~pclk;
  ea_arbiter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_req(irq_req), .irq_en(irq_en), .core_imask(core_imask), .instr_done(instr_done),
    .swi_exec(swi_exec), .rti_exec(rti_exec), .rst_src(rst_src), .stack_push(stack_push),
    .stack_pop(stack_pop), .stack_item(stack_item), .stack_pc_minus1(pc_m1), .set_imask(set_imask),
    .vector_fetch(vector_fetch), .vector_sel(vector_sel), .drop_prefetch(drop_prefetch),
    .brk_req(brk_req), .brk_active(brk_active), .flag_protect(flag_protect));
  ea_core_model core (.pclk(pclk), .presetn(presetn), .stack_push(stack_push), .stack_pop(stack_pop),
    .stack_item(stack_item), .set_imask(set_imask), .vector_fetch(vector_fetch), .hold_mask(hold_mask),
    .do_rti(do_rti), .instr_done(instr_done), .rti_exec(rti_exec), .core_imask(core_imask));
  // ****************
  // helpers
  // ****************
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task wfetch();
    pcm = 1'h0;
    do begin
      @(posedge pclk);
      if (stack_push === 1'h1) begin
        swi_exec <= 1'h0;
        brk_req <= 1'h0;
        pcm = pcm | pc_m1;
      end
    end while (vector_fetch !== 1'h1);
  endtask : wfetch
  task return_from_interrupt();
    n = 0;
    dp = 1'h0;
    do_rti <= 1'h1;
    do @(posedge pclk); while (stack_pop !== 1'h1);
    do_rti <= 1'h0;
    while (stack_pop === 1'h1) begin
      n++;
      dp = dp | drop_prefetch;
      @(posedge pclk);
    end
  endtask : return_from_interrupt
  task quiet();
    pcm = 1'h0;
    repeat (12) begin
      @(posedge pclk);
      pcm = pcm | stack_push;
    end
  endtask : quiet
  // ****************
  // scenarios
  // ****************
  task s_regs();
    apb(1'h0, EA_IDX_PEND_MID, 32'h0);
    chk("mid_rst", rd, 32'h0);
    irq_req <= 16'hA5C3;
    quiet();
    chk("disabled", 32'(pcm), 32'h0);
    apb(1'h1, EA_IDX_PEND_LOW, 32'hFF);
    apb(1'h0, EA_IDX_PEND_LOW, 32'h0);
    chk("low", rd, {24'h0, irq_req[5:0], 2'h0});
    apb(1'h0, EA_IDX_PEND_MID, 32'h0);
    chk("mid", rd, {24'h0, irq_req[13:6]});
    apb(1'h0, EA_IDX_PEND_HIGH, 32'h0);
    chk("high", rd, {30'h0, irq_req[15:14]});
    apb(1'h0, 16'hFE07, 32'h0);
    chk("unmapped", 32'(er), 32'h1);
    irq_req <= 16'h0;
  endtask : s_regs
  task s_prio();
    irq_en <= 16'hFFFF;
    irq_req <= 16'h0208;
    do @(posedge pclk); while (stack_push !== 1'h1);
    // a higher flag arriving after the latch must not take over
    irq_req <= 16'h0209;
    wfetch();
    chk("vec_a", 32'(vector_sel), 32'(EA_VEC_FLAG_BASE + 5'h3));
    chk("hw_pc", 32'(pcm), 32'h1);
    irq_req <= 16'h0200;
    return_from_interrupt();
    chk("pops", 32'(n), 32'h5);
    chk("redo", 32'(dp), 32'h1);
    wfetch();
    chk("vec_b", 32'(vector_sel), 32'(EA_VEC_FLAG_BASE + 5'h9));
    irq_req <= 16'h0;
    return_from_interrupt();
    chk("no_redo", 32'(dp), 32'h0);
  endtask : s_prio
  task s_swi();
    hold_mask <= 1'h1;
    irq_req <= 16'h0020;
    quiet();
    chk("masked", 32'(pcm), 32'h0);
    swi_exec <= 1'h1;
    wfetch();
    chk("swi_vec", 32'(vector_sel), 32'(EA_VEC_SWI));
    chk("swi_pc", 32'(pcm), 32'h0);
    return_from_interrupt();
    hold_mask <= 1'h0;
    wfetch();
    chk("unmasked", 32'(vector_sel), 32'(EA_VEC_FLAG_BASE + 5'h5));
    irq_req <= 16'h0;
    return_from_interrupt();
  endtask : s_swi
  task s_brk();
    brk_req <= 1'h1;
    wfetch();
    chk("brk_vec", 32'(vector_sel), 32'(EA_VEC_SWI));
    repeat (2) @(posedge pclk);
    chk("protect", 32'(flag_protect), 32'h1);
    apb(1'h1, EA_IDX_BRK_CTRL, 32'h1);
    apb(1'h0, EA_IDX_BRK_CTRL, 32'h0);
    chk("break_clear_enable", 32'(rd[0]), 32'h1);
    chk("clearable", 32'(flag_protect), 32'h0);
    apb(1'h1, EA_IDX_BRK_CTRL, 32'h0);
    @(posedge pclk);
    chk("reprotect", 32'(flag_protect), 32'h1);
    return_from_interrupt();
    @(posedge pclk);
    chk("brk_end", 32'({brk_active, flag_protect}), 32'h0);
  endtask : s_brk
  task s_rst();
    swi_exec <= 1'h1;
    rst_src <= 1'h1;
    @(posedge pclk);
    swi_exec <= 1'h0;
    rst_src <= 1'h0;
    @(posedge pclk);
    chk("rst_vec", 32'({vector_fetch, vector_sel}), 32'({1'h1, EA_VEC_RESET}));
  endtask : s_rst
  task results();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    s_regs();
    s_prio();
    s_swi();
    s_brk();
    s_rst();
    results();
  end
endmodule : tb_top
`default_nettype wire
